// ==== logic/nvc_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the nv access block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH

// Register offsets on the device register port
`define NVC_OFS_UNLOCK_KEY 8'h31
`define NVC_OFS_READY 8'h32
`define NVC_OFS_INDIV_ADDR 8'h33
`define NVC_OFS_INDIV_WRITE_DATA 8'h34
`define NVC_OFS_NV_ACCESS_CONTROL 8'h35
`define NVC_OFS_INDIV_READ_DATA 8'h36
`define NVC_OFS_MOTOR_HALT_CONTROL 8'h60
// First and last customer configuration location
`define NVC_CFG_FIRST 8'h90
`define NVC_CFG_LAST 8'h96
`define NVC_CFG_WORDS 7

// Access control field positions
`define NVC_METHOD_LSB 0
`define NVC_METHOD_MSB 1
`define NVC_DIR_BIT 2
`define NVC_RESYNC_BIT 8
`define NVC_SHADOW_BIT 12
// Motor halt bit position
`define NVC_HALT_BIT 15

// Access method codes
`define NVC_METHOD_OFF 2'h0
`define NVC_METHOD_INDIV 2'h1
`define NVC_METHOD_MASS 2'h2

// Unlock key for the customer space
`define NVC_UNLOCK_KEY_VAL 16'hc0de
// Reset value of every register
`define NVC_RESET_WORD 16'h0000

// Programming time of the store and clock period
`define NVC_PROG_TIME_NS 20000
`define NVC_CLK_PERIOD_NS 10
`define NVC_PROG_CYCLES ((`NVC_PROG_TIME_NS + `NVC_CLK_PERIOD_NS - 1) / `NVC_CLK_PERIOD_NS)

`endif

// ==== logic/nvc_pkg.sv ====
// Types shared by the nv access block.
// Assumes nvc_cfg.svh supplies all numeric constants.
package nvc_pkg;
  // One register or configuration word
  typedef logic [15:0] nvc_word_t;
  // Store programming sequencer
  typedef enum logic [0:0] {
    NVC_ST_IDLE,
    NVC_ST_PROG
  } nvc_state_t;
endpackage

// ==== logic/nvc_nv_store.sv ====
// Flip-flop model of the nonvolatile configuration array with programming delay.
// Assumes at most one write request per cycle and requests only while ready.
`timescale 1ns/1ns
`include "nvc_cfg.svh"
module nvc_nv_store
  import nvc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en, // Single word program
  input wire logic [2:0] wr_idx,
  input wire nvc_word_t wr_data,
  input wire logic bulk_en, // Program all words at once
  input wire logic [16*`NVC_CFG_WORDS-1:0] bulk_data,
  output logic [16*`NVC_CFG_WORDS-1:0] words, // Stored contents
  output logic ready // High when idle
);
  localparam logic [10:0] PROG_LAST = 11'(`NVC_PROG_CYCLES - 1);

  nvc_state_t state_r;
  nvc_state_t state_nxt;
  logic [10:0] cnt_r; // Busy time counter
  logic [10:0] cnt_nxt;
  wire start = wr_en | bulk_en;

  // Contents update at once; busy time only models the cell write
  genvar g;
  generate
    for (g = 0; g < `NVC_CFG_WORDS; g = g + 1) begin : g_word
      wire hit = wr_en && (wr_idx == 3'(g));
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          words[16*g +: 16] <= `NVC_RESET_WORD;
        end else if (bulk_en) begin
          words[16*g +: 16] <= bulk_data[16*g +: 16];
        end else if (hit) begin
          words[16*g +: 16] <= wr_data;
        end
      end
    end
  endgenerate

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      NVC_ST_IDLE: begin
        if (start) begin
          state_nxt = NVC_ST_PROG;
          cnt_nxt = 11'h000;
        end
      end
      NVC_ST_PROG: begin
        if (cnt_r == PROG_LAST) begin
          state_nxt = NVC_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 11'h001;
        end
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= NVC_ST_IDLE;
      cnt_r <= 11'h000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign ready = (state_r == NVC_ST_IDLE);
endmodule

// ==== logic/nvc_shadow.sv ====
// Shadow copy of the configuration words, written by the host or reloaded whole.
// Assumes load_all and wr_en are one-cycle pulses from the register logic.
`timescale 1ns/1ns
`include "nvc_cfg.svh"
module nvc_shadow
  import nvc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load_all, // Copy whole store image
  input wire logic [16*`NVC_CFG_WORDS-1:0] load_data,
  input wire logic wr_en, // Host word write
  input wire logic [2:0] wr_idx,
  input wire nvc_word_t wr_data,
  output logic [16*`NVC_CFG_WORDS-1:0] words
);
  // Reload wins over a host write in the same cycle
  genvar g;
  generate
    for (g = 0; g < `NVC_CFG_WORDS; g = g + 1) begin : g_word
      wire hit = wr_en && (wr_idx == 3'(g));
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          words[16*g +: 16] <= `NVC_RESET_WORD;
        end else if (load_all) begin
          words[16*g +: 16] <= load_data[16*g +: 16];
        end else if (hit) begin
          words[16*g +: 16] <= wr_data;
        end
      end
    end
  endgenerate
endmodule

// ==== logic/nvc_access_regs.sv ====
// Register front end of the nonvolatile configuration store.
// Assumes the serial slave presents one-cycle read and write strobes on CLK.
// Summary of operation
// - Write data word is programmed at selected location
// - Shadow select drives configuration from shadow words
// - Config reads return shadow words when selected
// - Resync bit copies store into shadow
// - Direction bit: zero reads, one writes
// - Method field: off, individual, mass, reserved
// - Read data holds last individual read
// - Halt bit one stops the motor
// - Halt bit always reads back zero
// - Reserved control bits read as zero
// - Unused addresses read zero, ignore writes
// - Address register picks individual location
// - Ready flag low while store busy
`timescale 1ns/1ns
`include "nvc_cfg.svh"
module nvc_access_regs
  import nvc_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] REG_ADDR, // Register offset
  input wire nvc_word_t REG_WDATA,
  input wire logic REG_WE, // Write strobe
  input wire logic REG_RE, // Read strobe
  output nvc_word_t REG_RDATA, // Valid the cycle after REG_RE
  output logic MOTOR_HALT, // High stops the motor
  output logic [16*`NVC_CFG_WORDS-1:0] CFG_WORDS // Operating configuration
);
  nvc_word_t key_r; // Unlock key
  logic [7:0] ind_addr_r; // Individual location select
  nvc_word_t indiv_write_word_r;
  nvc_word_t indiv_read_word_r;
  logic [1:0] nv_access_method_r;
  logic write_not_read_select_r;
  logic shadow_override_select_r;
  logic motor_halt_bit_r;
  nvc_word_t rdata_r;
  logic [16*`NVC_CFG_WORDS-1:0] nv_words; // Store contents
  logic [16*`NVC_CFG_WORDS-1:0] sh_words; // Shadow contents
  logic nv_ready_flag;

  // Address decode
  wire hit_key = (REG_ADDR == `NVC_OFS_UNLOCK_KEY);
  wire hit_rdy = (REG_ADDR == `NVC_OFS_READY);
  wire hit_addr = (REG_ADDR == `NVC_OFS_INDIV_ADDR);
  wire hit_wd = (REG_ADDR == `NVC_OFS_INDIV_WRITE_DATA);
  wire hit_ctrl = (REG_ADDR == `NVC_OFS_NV_ACCESS_CONTROL);
  wire hit_rd = (REG_ADDR == `NVC_OFS_INDIV_READ_DATA);
  wire hit_halt = (REG_ADDR == `NVC_OFS_MOTOR_HALT_CONTROL);
  wire hit_cfg = (REG_ADDR >= `NVC_CFG_FIRST) && (REG_ADDR <= `NVC_CFG_LAST);
  wire [2:0] cfg_idx = REG_ADDR[2:0]; // First location has low bits zero

  wire key_ok = (key_r == `NVC_UNLOCK_KEY_VAL);
  wire ind_in_range = (ind_addr_r >= `NVC_CFG_FIRST) && (ind_addr_r <= `NVC_CFG_LAST);
  wire [2:0] ind_idx = ind_addr_r[2:0];

  // Control write fields take effect from the value being written
  wire ctrl_we = REG_WE && hit_ctrl;
  wire [1:0] wr_method = REG_WDATA[`NVC_METHOD_MSB:`NVC_METHOD_LSB];
  wire wr_dir = REG_WDATA[`NVC_DIR_BIT];
  // A busy store or missing key makes an individual or mass trigger a no-op
  wire go = ctrl_we && nv_ready_flag && key_ok;
  wire is_ind = (wr_method == `NVC_METHOD_INDIV);
  wire is_mass = (wr_method == `NVC_METHOD_MASS);
  wire ind_wr_go = go && is_ind && wr_dir && ind_in_range;
  wire ind_rd_go = go && is_ind && !wr_dir && ind_in_range;
  wire mass_wr_go = go && is_mass && wr_dir;
  wire mass_rd_go = go && is_mass && !wr_dir;
  wire resync_go = ctrl_we && REG_WDATA[`NVC_RESYNC_BIT] && nv_ready_flag;
  wire sh_load = resync_go || mass_rd_go;
  // Host writes to customer space land in the shadow words
  wire sh_wr = REG_WE && hit_cfg && key_ok;

  // Selected store word for individual reads and host reads
  wire nvc_word_t nv_ind_word = nv_words[16*ind_idx +: 16];
  wire nvc_word_t nv_cfg_word = nv_words[16*cfg_idx +: 16];
  wire nvc_word_t sh_cfg_word = sh_words[16*cfg_idx +: 16];
  wire nvc_word_t cfg_rd_word = shadow_override_select_r ? sh_cfg_word : nv_cfg_word;

  // Control readback; resync reads zero as it is a trigger
  wire nvc_word_t ctrl_rd = {3'h0, shadow_override_select_r, 3'h0, 1'b0, 5'h00,
                             write_not_read_select_r, nv_access_method_r};

  // Read mux; unused and halt addresses give zero
  wire nvc_word_t rd_mux =
    hit_key ? key_r :
    hit_rdy ? {15'h0000, nv_ready_flag} :
    hit_addr ? {8'h00, ind_addr_r} :
    hit_wd ? indiv_write_word_r :
    hit_ctrl ? ctrl_rd :
    hit_rd ? indiv_read_word_r :
    hit_cfg ? cfg_rd_word :
    16'h0000;

  // Store array
  nvc_nv_store u_store (
    .clk(CLK),
    .arst_n(ARST_N),
    .wr_en(ind_wr_go),
    .wr_idx(ind_idx),
    .wr_data(indiv_write_word_r),
    .bulk_en(mass_wr_go),
    .bulk_data(sh_words),
    .words(nv_words),
    .ready(nv_ready_flag)
  );

  // Shadow bank
  nvc_shadow u_shadow (
    .clk(CLK),
    .arst_n(ARST_N),
    .load_all(sh_load),
    .load_data(nv_words),
    .wr_en(sh_wr),
    .wr_idx(cfg_idx),
    .wr_data(REG_WDATA),
    .words(sh_words)
  );

  // Key, address and write data registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      key_r <= `NVC_RESET_WORD;
      ind_addr_r <= 8'h00;
      indiv_write_word_r <= `NVC_RESET_WORD;
    end else if (REG_WE) begin
      if (hit_key) key_r <= REG_WDATA;
      if (hit_addr) ind_addr_r <= REG_WDATA[7:0];
      if (hit_wd) indiv_write_word_r <= REG_WDATA;
    end
  end

  // Access control fields; reserved bits are never stored
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      nv_access_method_r <= `NVC_METHOD_OFF;
      write_not_read_select_r <= 1'b0;
      shadow_override_select_r <= 1'b0;
    end else if (ctrl_we) begin
      nv_access_method_r <= wr_method;
      write_not_read_select_r <= wr_dir;
      shadow_override_select_r <= REG_WDATA[`NVC_SHADOW_BIT];
    end
  end

  // Individual read capture
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      indiv_read_word_r <= `NVC_RESET_WORD;
    end else if (ind_rd_go) begin
      indiv_read_word_r <= nv_ind_word;
    end
  end

  // Write-only motor halt bit
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      motor_halt_bit_r <= 1'b0;
    end else if (REG_WE && hit_halt) begin
      motor_halt_bit_r <= REG_WDATA[`NVC_HALT_BIT];
    end
  end

  // Registered read data
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_r <= `NVC_RESET_WORD;
    end else if (REG_RE) begin
      rdata_r <= rd_mux;
    end
  end

  assign REG_RDATA = rdata_r;
  assign MOTOR_HALT = motor_halt_bit_r;
  // Operating configuration follows the shadow only when selected
  assign CFG_WORDS = shadow_override_select_r ? sh_words : nv_words;

  chk_write_programs: assert property (@(posedge CLK) disable iff (!ARST_N)
    ind_wr_go |=> nv_words[16*$past(ind_idx) +: 16] == $past(indiv_write_word_r))
    else $error("individual write did not program the word");

  // Source follows the shadow bit as the host wrote it
  chk_cfg_source: assert property (@(posedge CLK) disable iff (!ARST_N)
    ctrl_we |=> CFG_WORDS == ($past(REG_WDATA[`NVC_SHADOW_BIT]) ? sh_words : nv_words))
    else $error("configuration source wrong");

  chk_shadow_read: assert property (@(posedge CLK) disable iff (!ARST_N)
    (REG_RE && hit_cfg && shadow_override_select_r && !sh_wr) |=> REG_RDATA == $past(sh_cfg_word))
    else $error("config read did not return shadow word");

  chk_resync_copy: assert property (@(posedge CLK) disable iff (!ARST_N)
    resync_go |=> sh_words == $past(nv_words))
    else $error("resync did not copy store into shadow");

  chk_read_capture: assert property (@(posedge CLK) disable iff (!ARST_N)
    ind_rd_go |=> indiv_read_word_r == $past(nv_ind_word) ##1 1'b1)
    else $error("individual read data not captured");

  chk_halt_set: assert property (@(posedge CLK) disable iff (!ARST_N)
    (REG_WE && hit_halt) |=> MOTOR_HALT == $past(REG_WDATA[`NVC_HALT_BIT]))
    else $error("motor halt does not follow write");

  chk_halt_hidden: assert property (@(posedge CLK) disable iff (!ARST_N)
    (REG_RE && hit_halt) |=> REG_RDATA == 16'h0000)
    else $error("motor halt register read back nonzero");

  chk_ctrl_reserved: assert property (@(posedge CLK) disable iff (!ARST_N)
    (REG_RE && hit_ctrl) |=> (REG_RDATA & 16'heef8) == 16'h0000)
    else $error("reserved control bits read nonzero");

  chk_unused_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
    (REG_RE && ((REG_ADDR >= 8'h37 && REG_ADDR <= 8'h5f) || (REG_ADDR >= 8'h61 &&
    REG_ADDR <= 8'h8f))) |=> REG_RDATA == 16'h0000)
    else $error("unused address read nonzero");

  chk_busy_ready: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ind_wr_go || mass_wr_go) |=> !nv_ready_flag [*8])
    else $error("ready flag not low during programming");

  chk_key_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ctrl_we && !key_ok) |=> $stable(nv_words) && $stable(indiv_read_word_r))
    else $error("store accessed without unlock key");

  // Watchers below look at outputs and state as well as at the trigger decode
  // Busy watcher: cycles since a program start, saturating
  // Saturation keeps a long idle spell from wrapping into the window
  localparam logic [11:0] BUSY_LAST = 12'(`NVC_PROG_CYCLES);
  localparam logic [11:0] BUSY_DONE = 12'(`NVC_PROG_CYCLES + 1);
  logic [11:0] busy_seen_r; // Zero when no program ran
  wire busy_idle = (busy_seen_r == 12'h000);
  wire busy_sat = (busy_seen_r == 12'hfff);

  // Count from one after the start edge; stop at the ceiling
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_seen_r <= 12'h000;
    end else if (ind_wr_go || mass_wr_go) begin
      busy_seen_r <= 12'h001;
    end else if (!busy_idle && !busy_sat) begin
      busy_seen_r <= busy_seen_r + 12'h001;
    end
  end

  // Ready stays low for the whole programming time
  chk_busy_span: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!busy_idle && busy_seen_r <= BUSY_LAST) |-> !nv_ready_flag)
    else $error("ready flag rose before programming ended");

  // Ready returns as soon as the programming time has run out
  chk_busy_end: assert property (@(posedge CLK) disable iff (!ARST_N)
    (busy_seen_r == BUSY_DONE) |-> nv_ready_flag)
    else $error("ready flag did not return after programming");

  // A trigger while busy leaves store, shadow and read data alone
  chk_busy_refuse: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ctrl_we && !nv_ready_flag) |=> $stable(nv_words) && $stable(sh_words)
    && $stable(indiv_read_word_r))
    else $error("access started while store busy");

  // Access disabled leaves store and read data alone
  chk_method_off: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ctrl_we && wr_method == `NVC_METHOD_OFF) |=> $stable(nv_words)
    && $stable(indiv_read_word_r))
    else $error("disabled access touched the store");

  // Location outside the customer space is ignored
  chk_addr_range: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ctrl_we && is_ind && !ind_in_range) |=> $stable(nv_words)
    && $stable(indiv_read_word_r))
    else $error("out of range location accessed");

  // Mass write programs every word from the shadow copy
  chk_mass_write: assert property (@(posedge CLK) disable iff (!ARST_N)
    mass_wr_go |=> nv_words == $past(sh_words))
    else $error("mass write did not copy shadow into store");

  // Mass read reloads every shadow word from the store
  chk_mass_read: assert property (@(posedge CLK) disable iff (!ARST_N)
    mass_rd_go |=> sh_words == $past(nv_words))
    else $error("mass read did not reload shadow");

  // Reads never alter the store
  chk_read_keeps: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ind_rd_go || mass_rd_go) |=> $stable(nv_words))
    else $error("read changed the store");

  // Read data only moves on an individual read
  chk_indiv_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
    !ind_rd_go |=> $stable(indiv_read_word_r))
    else $error("individual read data changed without a read");

  // Customer space writes without the key are dropped
  chk_key_write: assert property (@(posedge CLK) disable iff (!ARST_N)
    (REG_WE && hit_cfg && !key_ok) |=> $stable(sh_words))
    else $error("shadow written without unlock key");

  // Outputs sit at zero while reset is applied
  chk_reset_clear: assert property (@(posedge CLK)
    !ARST_N |=> (REG_RDATA == 16'h0000 && !MOTOR_HALT
    && CFG_WORDS == '0))
    else $error("outputs not cleared by reset");
endmodule

// ==== verification/nvc_host_model.sv ====
// Host model of the serial master that reaches the nv access registers.
// Assumes one-cycle strobes sampled on the rising clk edge, read data one cycle later.
`timescale 1ns/1ns
`include "nvc_cfg.svh"
module nvc_host_model
  import nvc_pkg::*;
(
  input wire logic clk,
  output logic [7:0] reg_addr,
  output nvc_word_t reg_wdata,
  output logic reg_we,
  output logic reg_re,
  input wire nvc_word_t reg_rdata
);
  // Idle cycles before each request, raised to act as a slow host
  int gap = 0;

  // Quiet bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_we = 1'b0;
    reg_re = 1'b0;
  end

  // One write; idle bus shows inverted values so nothing stale looks valid
  task automatic reg_write(input logic [7:0] a, input nvc_word_t d);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(posedge clk);
    #1;
    reg_we = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // One read; data is taken just after the sampling edge
  task automatic reg_read(input logic [7:0] a, output nvc_word_t d);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_re = 1'b1;
    @(posedge clk);
    #1;
    reg_re = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // Poll ready until it reads one, bounded to avoid a hang
  task automatic wait_ready(output logic ok);
    nvc_word_t s;
    ok = 1'b0;
    for (int i = 0; i < 1100 && !ok; i++) begin
      reg_read(`NVC_OFS_READY, s);
      ok = (s[0] === 1'b1);
    end
  endtask

  // Programming sequence: halt, key, address, data, trigger
  task automatic program_word(input logic [7:0] a, input nvc_word_t d);
    reg_write(`NVC_OFS_MOTOR_HALT_CONTROL, 16'h8000);
    reg_write(`NVC_OFS_UNLOCK_KEY, `NVC_UNLOCK_KEY_VAL);
    reg_write(`NVC_OFS_INDIV_ADDR, {8'h00, a});
    reg_write(`NVC_OFS_INDIV_WRITE_DATA, d);
    reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0005);
  endtask
endmodule

// ==== verification/nvc_testbench.sv ====
// Self-checking bench for the nv access register block.
// Assumes the host model drives the register port and the design holds its own checks.
`timescale 1ns/1ns
`include "nvc_cfg.svh"
module testbench;
  import nvc_pkg::*;
  logic clk = 1'b0; // 100 MHz clock
  logic arst_n = 1'b0; // Reset held at start
  logic [7:0] reg_addr;
  nvc_word_t reg_wdata;
  logic reg_we;
  logic reg_re;
  nvc_word_t reg_rdata;
  logic motor_halt;
  logic [16*`NVC_CFG_WORDS-1:0] cfg_words;
  nvc_word_t v; // Last value read
  logic ok; // Ready seen within bound
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  nvc_access_regs dut (.CLK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata),
    .MOTOR_HALT(motor_halt), .CFG_WORDS(cfg_words));

  nvc_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));

  // Operating word k of the configuration image
  function automatic nvc_word_t cfg(input int k);
    return cfg_words[16*k +: 16];
  endfunction

  // Single comparison point
  task automatic check(input string name, input nvc_word_t seen, input nvc_word_t exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read one register and compare
  task automatic rd_chk(input string name, input logic [7:0] a, input nvc_word_t exp);
    host.reg_read(a, v);
    check(name, v, exp);
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard: programming waits need about 4000 cycles in all
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    // Reset values and ready
    rd_chk("wdata_rst", `NVC_OFS_INDIV_WRITE_DATA, 16'h0000);
    rd_chk("ctrl_rst", `NVC_OFS_NV_ACCESS_CONTROL, 16'h0000);
    rd_chk("rdata_rst", `NVC_OFS_INDIV_READ_DATA, 16'h0000);
    check("halt_rst", {15'h0000, motor_halt}, 16'h0000);
    rd_chk("ready_rst", `NVC_OFS_READY, 16'h0001);
    $display("test reset done");
    // Field storage, reserved bits, halt bit, unused space
    host.reg_write(`NVC_OFS_INDIV_WRITE_DATA, 16'ha5c3);
    rd_chk("wdata_rw", `NVC_OFS_INDIV_WRITE_DATA, 16'ha5c3);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'hfef8);
    rd_chk("ctrl_rsvd", `NVC_OFS_NV_ACCESS_CONTROL, 16'h1000);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0000);
    host.reg_write(`NVC_OFS_MOTOR_HALT_CONTROL, 16'h8000);
    check("halt_on", {15'h0000, motor_halt}, 16'h0001);
    rd_chk("halt_wo", `NVC_OFS_MOTOR_HALT_CONTROL, 16'h0000);
    host.reg_write(`NVC_OFS_MOTOR_HALT_CONTROL, 16'h0000);
    check("halt_off", {15'h0000, motor_halt}, 16'h0000);
    host.reg_write(8'h37, 16'hffff);
    rd_chk("unused_37", 8'h37, 16'h0000);
    host.reg_write(8'h8f, 16'hffff);
    rd_chk("unused_8f", 8'h8f, 16'h0000);
    $display("test fields done");
    // Individual write with busy time, then individual reads
    host.gap = 2;
    host.program_word(8'h92, 16'h1234);
    host.gap = 0;
    rd_chk("busy", `NVC_OFS_READY, 16'h0000);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0001);
    rd_chk("busy_refuse", `NVC_OFS_INDIV_READ_DATA, 16'h0000);
    host.wait_ready(ok);
    check("ready_back", {15'h0000, ok}, 16'h0001);
    check("cfg2_store", cfg(2), 16'h1234);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0001);
    rd_chk("indiv_rd", `NVC_OFS_INDIV_READ_DATA, 16'h1234);
    host.reg_write(`NVC_OFS_INDIV_ADDR, 16'h0097);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0001);
    rd_chk("indiv_range", `NVC_OFS_INDIV_READ_DATA, 16'h1234);
    host.reg_write(`NVC_OFS_INDIV_ADDR, 16'h0090);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0001);
    rd_chk("indiv_rd90", `NVC_OFS_INDIV_READ_DATA, 16'h0000);
    check("cfg0_kept", cfg(0), 16'h0000);
    $display("test individual done");
    // Shadow select and resync
    host.reg_write(8'h92, 16'hbeef);
    check("cfg2_noshadow", cfg(2), 16'h1234);
    rd_chk("rd92_store", 8'h92, 16'h1234);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h1000);
    check("cfg2_shadow", cfg(2), 16'hbeef);
    rd_chk("rd92_shadow", 8'h92, 16'hbeef);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h1100);
    check("cfg2_resync", cfg(2), 16'h1234);
    rd_chk("resync_clr", `NVC_OFS_NV_ACCESS_CONTROL, 16'h1000);
    $display("test shadow done");
    // Mass write copies shadow into the store, mass read reloads the shadow from it
    host.reg_write(8'h93, 16'h5a5a);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h1006);
    rd_chk("mass_busy", `NVC_OFS_READY, 16'h0000);
    host.wait_ready(ok);
    check("mass_ready", {15'h0000, ok}, 16'h0001);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0000);
    check("cfg3_mass", cfg(3), 16'h5a5a);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0004);
    rd_chk("off_idle", `NVC_OFS_READY, 16'h0001);
    host.reg_write(8'h94, 16'h4444);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h1002);
    check("cfg4_massrd", cfg(4), 16'h0000);
    $display("test mass done");
    // Wrong key blocks an individual write
    host.reg_write(`NVC_OFS_UNLOCK_KEY, 16'h0000);
    host.reg_write(`NVC_OFS_INDIV_ADDR, 16'h0094);
    host.reg_write(`NVC_OFS_INDIV_WRITE_DATA, 16'h7777);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h0005);
    rd_chk("nokey_idle", `NVC_OFS_READY, 16'h0001);
    check("cfg4_nokey", cfg(4), 16'h0000);
    host.reg_write(`NVC_OFS_NV_ACCESS_CONTROL, 16'h1000);
    host.reg_write(8'h94, 16'h7777);
    check("cfg4_shnokey", cfg(4), 16'h0000);
    $display("test key done");
    print_verdict();
  end
endmodule
